// ### src/vprot_pkg.sv
/*
  Shared constants and types of the voltage protection element:
  register offsets, control field layout, reset values and timing counts.
  Assumes a 25 MHz APB clock and 16-bit unsigned measurement words.
*/
package vprot_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] THRESH_OFS   = 8'h04;
  localparam logic [7:0] SEC_OFS      = 8'h08;
  localparam logic [7:0] IMIN_OFS     = 8'h0C;
  localparam logic [7:0] TDELAY_OFS   = 8'h10;
  localparam logic [7:0] IDELAY_OFS   = 8'h14;
  localparam logic [7:0] STATUS_OFS   = 8'h18;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h1C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h20;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_W       = 10;
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_ALARM    = 0;
  localparam int          IRQ_TRIP     = 1;
  localparam int          IRQ_BLOCK    = 2;
  localparam logic [15:0] THRESH_RST   = 16'h0E66;  // 0.9 in Q4.12
  localparam logic [15:0] SEC_RST      = 16'h2710;
  localparam logic [15:0] IMIN_RST     = 16'h0064;
  localparam logic [31:0] TDELAY_RST   = 32'h0000_C350;
  localparam logic [31:0] IDELAY_RST   = 32'h0000_C350;
  localparam int          Q_FRAC       = 12;           // threshold fraction bits
  localparam logic [15:0] PLOSS_FRAC   = 16'h007B;     // 0.03 in Q4.12
  localparam logic [15:0] INV_SQRT3    = 16'h093C;     // 1/sqrt(3) in Q4.12

  // Measuring method encodings
  localparam logic [1:0]  METH_FUND    = 2'h0;
  localparam logic [1:0]  METH_RMS     = 2'h1;
  localparam logic [1:0]  METH_AVG     = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ        = 25_000_000;
  localparam longint TSUP_DET_MS   = 20;
  localparam longint PLOSS_DIN_MS  = 20;
  localparam longint PLOSS_MEAS_MS = 30;
  localparam longint AVG_WINDOW_S  = 600;            // ten minutes
  localparam int     AVG_DEPTH     = 16;
  localparam longint TSUP_CYC      = TSUP_DET_MS * CLK_HZ / 1000;
  localparam longint PLOSS_DIN_CYC = PLOSS_DIN_MS * CLK_HZ / 1000;
  localparam longint PLOSS_MEAS_CYC = PLOSS_MEAS_MS * CLK_HZ / 1000;
  localparam longint AVG_STEP_CYC  = AVG_WINDOW_S * CLK_HZ / AVG_DEPTH;

  // ----------------------------------------------------------------
  // Control register carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ploss_en;     // bit 9
    logic       tsup_en;      // bit 8
    logic       supv_en;      // bit 7 measuring-circuit supervision
    logic       ext_fn;       // bit 6 external block function
    logic       imin_en;      // bit 5
    logic       conn_pp;      // bit 4 transformer_connection phase-phase
    logic       meas_pp;      // bit 3 measuring mode phase-phase
    logic [1:0] method;       // bits 2:1
    logic       under;        // bit 0 undervoltage mode
  } ctrl_s;

  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

endpackage

// ### src/persist_timer.sv
/*
  Persistence timer: done rises once cond has held for limit cycles.
  Assumes cond comes from logic on the same clock.
*/
`timescale 1ns/10ps
module persist_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Timing
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  output logic              done_reg
);

  logic [W-1:0] count_reg;

  // ----------------------------------------------------------------
  // Count while the condition holds, restart when it drops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end else if (!cond) begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end else begin
      if (count_reg < limit)
        count_reg <= count_reg + W'(1);
      done_reg <= (count_reg + W'(1) >= limit);  // Least one cycle
    end
  end

endmodule // persist_timer

// ### src/sliding_average.sv
/*
  Sliding average of three phase voltages over a window of DEPTH samples.
  Assumes step cycles between samples gives the full window length.
*/
`timescale 1ns/10ps
module sliding_average #(
  parameter int     DEPTH = 16,
  parameter longint STEP  = 937_500_000
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Samples in, averages out
  input  wire logic [47:0] volt,
  output logic      [47:0] avg_reg
);

  localparam int AW = $clog2(DEPTH);

  logic [15:0]    mem [3][DEPTH];
  logic [15+AW:0] sum_reg [3];
  logic [AW-1:0]  wr_reg;
  logic [39:0]    tick_reg;

  // ----------------------------------------------------------------
  // Sample tick
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_reg <= '0;
    else if (tick_reg >= 40'(STEP - 1))
      tick_reg <= '0;
    else
      tick_reg <= tick_reg + 40'h1;
  end

  // ----------------------------------------------------------------
  // Ring of samples with running sums
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      for (int p = 0; p < 3; p++) begin
        sum_reg[p] <= '0;
        avg_reg[p*16 +: 16] <= 16'h0000;
        for (int d = 0; d < DEPTH; d++)
          mem[p][d] <= 16'h0000;
      end
    end else if (tick_reg == '0) begin
      wr_reg <= wr_reg + AW'(1);
      for (int p = 0; p < 3; p++) begin
        mem[p][wr_reg] <= volt[p*16 +: 16];
        sum_reg[p] <= sum_reg[p] - (16+AW)'(mem[p][wr_reg]) + (16+AW)'(volt[p*16 +: 16]);
        avg_reg[p*16 +: 16] <= sum_reg[p][15+AW:AW];
      end
    end
  end

endmodule // sliding_average

// ### src/voltage_protection_element.sv
/*
  One voltage protection element with APB register file and interrupt.
  Assumes the measurement front end presents three channel voltages
  (fundamental and true RMS) and neutral-side phase currents on pclk.
*/
// How it works
// - One structure; control bit picks over- or undervoltage supervision.
// - Phase-to-ground connection: flags 1..3 follow phase-neutral voltages 1..3.
// - Phase-to-phase connection: flags 1..3 follow line voltages 12, 23, 31.
// - Method setting picks fundamental, true RMS or sliding average.
// - Sliding average spans a ten-minute window.
// - Phase-ground mode: nominal is rating over root three, else rating.
// - Phase-phase connection forces phase-phase mode, nominal equals rating.
// - Minimum-current block only acts in undervoltage mode.
// - All phase currents under threshold block the undervoltage element.
// - Any current back above threshold releases only after release delay.
// - Minimum-current check idle unless its enable is set.
// - Minimum-current check always uses neutral-side currents.
// - Potential-loss supervisor blocks undervoltage below 0.03 of nominal.
// - External block source blocks element when its function is active.
// - Supervision active plus fuse failure blocks undervoltage elements.
// - Transformer supervisor detects fuse failure within 20 ms.
// - Potential-loss detects in 20 ms by input, 30 ms by measurement.
`timescale 1ns/10ps
module voltage_protection_element #(
  parameter longint TSUP_CYC       = vprot_pkg::TSUP_CYC,
  parameter longint PLOSS_DIN_CYC  = vprot_pkg::PLOSS_DIN_CYC,
  parameter longint PLOSS_MEAS_CYC = vprot_pkg::PLOSS_MEAS_CYC,
  parameter longint AVG_STEP_CYC   = vprot_pkg::AVG_STEP_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Front-end measurements, channel 1 in bits 15:0
  input  wire logic [47:0] volt_fund,
  input  wire logic [47:0] volt_rms,
  input  wire logic [47:0] cur_neutral,
  input  wire logic [47:0] cur_terminal,
  input  wire logic        tsup_meas_fail,
  // Pins
  input  wire logic        external_block_source,
  input  wire logic        tsup_fuse_pin,
  input  wire logic        ploss_fuse_pin,
  // Flags
  output logic      [2:0]  phase_alarm,
  output logic      [2:0]  phase_trip,
  output logic             irq
);

  vprot_pkg::ctrl_s ctrl_reg;
  logic [15:0]  thresh_reg, sec_reg, imin_reg;
  logic [31:0]  tdelay_reg, idelay_reg;
  logic [2:0]   irq_stat_reg, irq_mask_reg, irq_event;
  logic [2:0]   ext_sync_reg, tsup_sync_reg, ploss_sync_reg;
  logic         ext_stable_reg, tsup_stable_reg, ploss_stable_reg;
  logic         imin_block_reg, release_done, tsup_done, ploss_din_done, ploss_meas_done;
  logic [47:0]  volt_avg, volt_sel;
  logic [15:0]  nominal, thr_abs, ploss_abs;
  logic [2:0]   cond, alarm_next, trip_done;
  logic         blocked, uv_block, all_low, any_live, ploss_low, ext_blk, fuse_fail;
  logic         wr_en, blocked_q, irq_pending;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Scale a nominal by a Q4.12 factor, saturating at full scale
  function automatic logic [15:0] scale(input logic [15:0] v, input logic [15:0] f);
    logic [31:0] p;
    p = v * f;
    scale = (|p[31:28]) ? 16'hFFFF : p[27:12];
  endfunction

  // Next state of a three-stage input synchroniser's accepted level
  function automatic logic agreed(input logic [2:0] s, input logic cur);
    agreed = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers: stage 0 feeds stage 1 only
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_reg     <= 3'h0;
      tsup_sync_reg    <= 3'h0;
      ploss_sync_reg   <= 3'h0;
      ext_stable_reg   <= 1'b0;
      tsup_stable_reg  <= 1'b0;
      ploss_stable_reg <= 1'b0;
    end else begin
      ext_sync_reg     <= {ext_sync_reg[1:0], external_block_source};
      tsup_sync_reg    <= {tsup_sync_reg[1:0], tsup_fuse_pin};
      ploss_sync_reg   <= {ploss_sync_reg[1:0], ploss_fuse_pin};
      ext_stable_reg   <= agreed(ext_sync_reg, ext_stable_reg);
      tsup_stable_reg  <= agreed(tsup_sync_reg, tsup_stable_reg);
      ploss_stable_reg <= agreed(ploss_sync_reg, ploss_stable_reg);
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  assign wr_en = psel & penable & pready & pwrite;

  // Single wait-free access: ready rises in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > vprot_pkg::IRQ_MASK_OFS | paddr[1:0] != 2'h0);
      if (psel & ~penable & ~pwrite) begin
        unique case (paddr)
          vprot_pkg::CTRL_OFS:     prdata <= {22'h0, ctrl_reg};
          vprot_pkg::THRESH_OFS:   prdata <= {16'h0, thresh_reg};
          vprot_pkg::SEC_OFS:      prdata <= {16'h0, sec_reg};
          vprot_pkg::IMIN_OFS:     prdata <= {16'h0, imin_reg};
          vprot_pkg::TDELAY_OFS:   prdata <= tdelay_reg;
          vprot_pkg::IDELAY_OFS:   prdata <= idelay_reg;
          vprot_pkg::STATUS_OFS:   prdata <= {23'h0, fuse_fail, imin_block_reg, blocked,
                                              phase_trip, phase_alarm};
          vprot_pkg::IRQ_STAT_OFS: prdata <= {29'h0, irq_stat_reg};
          vprot_pkg::IRQ_MASK_OFS: prdata <= {29'h0, irq_mask_reg};
          default:                 prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writable settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= vprot_pkg::CTRL_RST;
      thresh_reg   <= vprot_pkg::THRESH_RST;
      sec_reg      <= vprot_pkg::SEC_RST;
      imin_reg     <= vprot_pkg::IMIN_RST;
      tdelay_reg   <= vprot_pkg::TDELAY_RST;
      idelay_reg   <= vprot_pkg::IDELAY_RST;
      irq_mask_reg <= 3'h0;
    end else if (wr_en) begin
      unique case (paddr)
        vprot_pkg::CTRL_OFS:     ctrl_reg     <= pwdata[vprot_pkg::CTRL_W-1:0];
        vprot_pkg::THRESH_OFS:   thresh_reg   <= pwdata[15:0];
        vprot_pkg::SEC_OFS:      sec_reg      <= pwdata[15:0];
        vprot_pkg::IMIN_OFS:     imin_reg     <= pwdata[15:0];
        vprot_pkg::TDELAY_OFS:   tdelay_reg   <= pwdata;
        vprot_pkg::IDELAY_OFS:   idelay_reg   <= pwdata;
        vprot_pkg::IRQ_MASK_OFS: irq_mask_reg <= pwdata[2:0];
        default:                 ;
      endcase
    end
  end

  // Sticky events, write one to clear, set wins over clear
  // Block event marks the rise only; trip event only when the trip really lands
  assign irq_event   = {blocked & ~blocked_q,
                        |(trip_done & alarm_next & ~phase_trip),
                        |(alarm_next & ~phase_alarm)};
  // Unmasked status pending
  assign irq_pending = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 3'h0;
      blocked_q    <= 1'b0;
      irq          <= 1'b0;
    end else begin
      blocked_q <= blocked;
      if (wr_en && paddr == vprot_pkg::IRQ_STAT_OFS)
        irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_event;
      else
        irq_stat_reg <= irq_stat_reg | irq_event;
      irq <= irq_pending;
    end
  end

  // ----------------------------------------------------------------
  // Measurement selection and thresholds
  // ----------------------------------------------------------------
  sliding_average #(
    .DEPTH (vprot_pkg::AVG_DEPTH),
    .STEP  (AVG_STEP_CYC)
  ) avg_u (
    .pclk    (pclk),
    .presetn (presetn),
    .volt    (volt_fund),
    .avg_reg (volt_avg)
  );

  // Channel i drives flag i in either connection; the front end applies
  // phase-neutral or line voltages to the same three channels
  always_comb begin
    unique case (ctrl_reg.method)
      vprot_pkg::METH_RMS: volt_sel = volt_rms;
      vprot_pkg::METH_AVG: volt_sel = volt_avg;
      default:             volt_sel = volt_fund;
    endcase
  end

  // Nominal: phase-phase connection overrides the per-element mode
  assign nominal   = (ctrl_reg.conn_pp | ctrl_reg.meas_pp) ? sec_reg
                                                           : scale(sec_reg, vprot_pkg::INV_SQRT3);
  assign thr_abs   = scale(nominal, thresh_reg);
  assign ploss_abs = scale(nominal, vprot_pkg::PLOSS_FRAC);

  // Per-phase pickup
  always_comb begin
    for (int p = 0; p < 3; p++)
      cond[p] = ctrl_reg.under ? (volt_sel[p*16 +: 16] < thr_abs)
                               : (volt_sel[p*16 +: 16] > thr_abs);
  end

  // ----------------------------------------------------------------
  // Blocking
  // ----------------------------------------------------------------
  // Neutral-side currents only; terminal currents are not consulted
  assign all_low  = (cur_neutral[15:0] < imin_reg) & (cur_neutral[31:16] < imin_reg) &
                    (cur_neutral[47:32] < imin_reg);
  assign any_live = ~all_low;
  assign ploss_low = (volt_fund[15:0] < ploss_abs) & (volt_fund[31:16] < ploss_abs) &
                     (volt_fund[47:32] < ploss_abs);

  // Minimum-current block set at once, released after the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      imin_block_reg <= 1'b0;
    else if (!(ctrl_reg.imin_en & ctrl_reg.under))
      imin_block_reg <= 1'b0;
    else if (all_low)
      imin_block_reg <= 1'b1;
    else if (release_done)
      imin_block_reg <= 1'b0;
  end

  persist_timer #(.W(32)) release_u (
    .pclk     (pclk),
    .presetn  (presetn),
    .cond     (imin_block_reg & any_live),
    .limit    (idelay_reg),
    .done_reg (release_done)
  );

  persist_timer #(.W(32)) tsup_u (
    .pclk     (pclk),
    .presetn  (presetn),
    .cond     (ctrl_reg.tsup_en & (tsup_stable_reg | tsup_meas_fail)),
    .limit    (32'(TSUP_CYC)),
    .done_reg (tsup_done)
  );

  persist_timer #(.W(32)) ploss_din_u (
    .pclk     (pclk),
    .presetn  (presetn),
    .cond     (ctrl_reg.ploss_en & ploss_stable_reg),
    .limit    (32'(PLOSS_DIN_CYC)),
    .done_reg (ploss_din_done)
  );

  persist_timer #(.W(32)) ploss_meas_u (
    .pclk     (pclk),
    .presetn  (presetn),
    .cond     (ctrl_reg.ploss_en & ploss_low),
    .limit    (32'(PLOSS_MEAS_CYC)),
    .done_reg (ploss_meas_done)
  );

  assign fuse_fail = tsup_done | ploss_din_done;
  assign ext_blk   = ctrl_reg.ext_fn & ext_stable_reg;
  assign uv_block  = ctrl_reg.under & (imin_block_reg
                   | (ctrl_reg.supv_en & fuse_fail)
                   | ploss_meas_done);
  assign blocked   = ext_blk | uv_block;

  // ----------------------------------------------------------------
  // Alarm and trip
  // ----------------------------------------------------------------
  assign alarm_next = cond & {3{~blocked}};

  for (genvar g = 0; g < 3; g++) begin : g_trip
    persist_timer #(.W(32)) trip_u (
      .pclk     (pclk),
      .presetn  (presetn),
      .cond     (alarm_next[g]),
      .limit    (tdelay_reg),
      .done_reg (trip_done[g])
    );
  end

  // Flags clear as soon as the condition ends or a block appears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_alarm <= 3'h0;
      phase_trip  <= 3'h0;
    end else begin
      phase_alarm <= alarm_next;
      phase_trip  <= trip_done & alarm_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence apb_setup_s;
    psel && !penable;
  endsequence

  sequence uv_all_low_s;
    ctrl_reg.under && ctrl_reg.imin_en && all_low;
  endsequence

  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup_s |=> pready ##1 !pready) else $error("ready not one cycle after setup");
  trip_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
    phase_trip[0] |-> phase_alarm[0]) else $error("trip without alarm");
  block_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    blocked |=> phase_alarm == 3'h0 && phase_trip == 3'h0) else $error("flag during block");
  imin_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    uv_all_low_s |=> imin_block_reg ##1 (imin_block_reg || !ctrl_reg.imin_en || !ctrl_reg.under))
    else $error("min current block missed");
  imin_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg.imin_en |=> !imin_block_reg) else $error("min current check not idle");
  over_noblk_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg.under |-> !uv_block) else $error("undervoltage block in over mode");
  ext_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg.ext_fn && ext_stable_reg |=> phase_alarm == 3'h0) else $error("external block ignored");
  fuse_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg.under && ctrl_reg.supv_en && tsup_done |-> blocked) else $error("fuse failure ignored");
  pp_nominal_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg.conn_pp |-> nominal == sec_reg) else $error("nominal not forced");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == $past(irq_pending)) else $error("irq level wrong");

endmodule // voltage_protection_element

// ### verif/meas_front_end.sv
/*
  Measurement front end model: hands bench-set voltages and currents on.
  Assumes the bench changes its settings just after a pclk edge.
*/
`timescale 1ns/10ps
module meas_front_end (
  // Settings from the bench
  input  wire logic [47:0] vf,
  input  wire logic [47:0] vr,
  input  wire logic [15:0] cur,
  // Measurements to the element
  output logic      [47:0] volt_fund,
  output logic      [47:0] volt_rms,
  output logic      [47:0] cur_neutral,
  output logic      [47:0] cur_terminal,
  output logic             tsup_meas_fail
);
  // Voltages and neutral currents pass straight through
  assign volt_fund      = vf;
  assign volt_rms       = vr;
  assign cur_neutral    = {3{cur}};
  // Terminal side always live, so a current block shows neutral use
  assign cur_terminal   = 48'hFFFF_FFFF_FFFF;
  assign tsup_meas_fail = 1'b0;
endmodule // meas_front_end

// ### verif/test_voltage_protection_element.sv
/*
  Self-checking bench of the voltage protection element over APB.
  Assumes the register map and timing of the package, shortened counts.
*/
`timescale 1ns/10ps
module test_voltage_protection_element;
  logic pclk, presetn, psel, penable, pwrite, xblk, tpin, ppin, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr;
  logic [47:0] vf, vr, volt_fund, volt_rms, cur_neutral, cur_terminal;
  logic [15:0] cur;
  logic        tsup_meas_fail;
  logic [2:0]  phase_alarm, phase_trip;
  int n_fail = 0;
  int n_tests = 0;
  // Clock at 25 MHz
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  meas_front_end meas_front_end_inst (.vf(vf), .vr(vr), .cur(cur), .volt_fund(volt_fund),
    .volt_rms(volt_rms), .cur_neutral(cur_neutral), .cur_terminal(cur_terminal),
    .tsup_meas_fail(tsup_meas_fail));
  voltage_protection_element #(.TSUP_CYC(10), .PLOSS_DIN_CYC(10), .PLOSS_MEAS_CYC(10),
    .AVG_STEP_CYC(4)) voltage_protection_element_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .volt_fund(volt_fund),
    .volt_rms(volt_rms), .cur_neutral(cur_neutral), .cur_terminal(cur_terminal),
    .tsup_meas_fail(tsup_meas_fail), .external_block_source(xblk), .tsup_fuse_pin(tpin),
    .ploss_fuse_pin(ppin), .phase_alarm(phase_alarm), .phase_trip(phase_trip), .irq(irq));
  // Verdict and end of run
  task conclude();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Compare one value
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Poll flags (s=0) or irq (s=1) for a bounded time, then compare
  task expect_obs(input string n, input int s, input logic [31:0] e);
    int k;
    logic [31:0] g;
    for (k = 0; k < 200; k++) begin
      @(posedge pclk);
      g = s ? {31'h0, irq} : {26'h0, phase_trip, phase_alarm};
      if (g === e) break;
    end
    chk(n, e, g);
  endtask
  // Main sequence
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    xblk = 0; tpin = 0; ppin = 0; cur = 16'h0200; vf = {3{16'h0800}}; vr = {3{16'h0800}};
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h04, 0); chk("thresh", 32'h0000_0E66, q);
    apb(0, 8'h08, 0); chk("rating", 32'h0000_2710, q);
    apb(0, 8'h24, 0); chk("unmapped", 32'h1, {31'h0, err});
    $display("Test reset done");
    apb(1, 8'h08, 32'h1000); apb(1, 8'h04, 32'h1000);
    apb(1, 8'h10, 32'h4);
    apb(1, 8'h00, 32'h10); vf <= {16'h0800, 16'h1100, 16'h0800};
    expect_obs("over pp", 0, 32'h12);
    vf <= {3{16'h0800}}; expect_obs("over off", 0, 32'h0);
    apb(1, 8'h00, 32'h0); vf <= {16'h0A00, 16'h0800, 16'h0800};
    expect_obs("over pg", 0, 32'h24);
    apb(1, 8'h00, 32'h12); vf <= {3{16'h0800}}; vr <= {16'h0800, 16'h0800, 16'h1100};
    expect_obs("rms", 0, 32'h09);
    vr <= {3{16'h0800}};
    apb(1, 8'h00, 32'h14); vf <= {3{16'h1100}};
    repeat (8) @(posedge pclk);
    chk("avg lag", 32'h0, {26'h0, phase_trip, phase_alarm});
    expect_obs("avg", 0, 32'h3F);
    vf <= {3{16'h0800}};
    $display("Test over done");
    apb(1, 8'h14, 32'd20); apb(1, 8'h00, 32'h31); cur <= 16'h0;
    expect_obs("imin block", 0, 32'h0);
    repeat (20) @(posedge pclk);
    chk("imin hold", 32'h0, {26'h0, phase_trip, phase_alarm});
    cur <= 16'h0200; repeat (8) @(posedge pclk);
    chk("imin delay", 32'h0, {26'h0, phase_trip, phase_alarm});
    expect_obs("imin free", 0, 32'h3F);
    apb(1, 8'h00, 32'h1F1); xblk <= 1;
    expect_obs("ext block", 0, 32'h0);
    xblk <= 0; expect_obs("ext free", 0, 32'h3F);
    tpin <= 1; expect_obs("fuse block", 0, 32'h0);
    tpin <= 0; vf <= {3{16'h0000}}; apb(1, 8'h00, 32'h211);
    expect_obs("ploss", 0, 32'h0);
    repeat (20) @(posedge pclk);
    chk("ploss hold", 32'h0, {26'h0, phase_trip, phase_alarm});
    vf <= {3{16'h0800}}; apb(1, 8'h00, 32'h291);
    expect_obs("ploss pin free", 0, 32'h3F);
    ppin <= 1; expect_obs("ploss pin", 0, 32'h0);
    ppin <= 0;
    $display("Test under done");
    vf <= {3{16'h1800}}; apb(1, 8'h1C, 32'h7); apb(1, 8'h20, 32'h1);
    expect_obs("irq idle", 1, 32'h0);
    vf <= {3{16'h0800}}; expect_obs("irq set", 1, 32'h1);
    apb(0, 8'h1C, 0); chk("irq stat", 32'h1, q & 32'h1);
    vf <= {3{16'h1800}}; apb(1, 8'h1C, 32'h1);
    expect_obs("irq clear", 1, 32'h0);
    $display("Test irq done");
    conclude();
  end
endmodule // test_voltage_protection_element
